// ### sdm_defines.vh
`ifndef SDM_DEFINES_VH
`define SDM_DEFINES_VH

// Clock period of i_mclk in picoseconds.
`define SDM_CLK_PERIOD_PS   40'd25000

// Least time the confirm input must stay high to count as stuck, in ns.
`define SDM_STUCK_TIME_NS   40'd1000

// Edges after reset release before the synchronised pins are trusted.
`define SDM_SETTLE_W        2

// Width of the stuck-button counter.
`define SDM_STUCK_CNT_W     16

// One-hot state codes of the door sequence.
`define SDM_ST_W            6
`define SDM_ST_START        6'h01
`define SDM_ST_WAIT_OPEN    6'h02
`define SDM_ST_WAIT_CLOSE   6'h04
`define SDM_ST_WAIT_ACK     6'h08
`define SDM_ST_ENABLED      6'h10
`define SDM_ST_PASSIV       6'h20

// Service byte layout.
`define SDM_SVC_W           8
`define SDM_SVC_RSVD0       0
`define SDM_SVC_NO_OPEN     1
`define SDM_SVC_NO_CLOSE    2
`define SDM_SVC_PASSIV      3
`define SDM_SVC_RSVD4       4
`define SDM_SVC_STUCK       5
`define SDM_SVC_ACK_REQ     6
`define SDM_SVC_ENABLE      7

// Input vector layout ahead of the synchroniser.
`define SDM_IN_W            7
`define SDM_IN_SW_A         0
`define SDM_IN_SW_B         1
`define SDM_IN_PASS_A       2
`define SDM_IN_PASS_B       3
`define SDM_IN_OPEN_FIRST   4
`define SDM_IN_CONF_NEED    5
`define SDM_IN_CONFIRM      6

// Reset values: both settings start at 1, everything else at 0.
`define SDM_IN_RST          7'h30
`define SDM_SVC_RST         8'h00

`endif

// ### sdm_door_model.sv
`timescale 1ns/1ps

// Two position switches and a confirm button. Position 0 is fully open,
// 1 closed, 2 half open with only switch a released. A passivated source
// reads 0, so the monitor must not mistake it for an opening.
module sdm_door_model (
  input  wire [1:0] i_pos,
  input  wire       i_press,
  input  wire       i_pass_a,
  output wire       o_door_switch_a,
  output wire       o_door_switch_b,
  output wire       o_pass_flag_a,
  output wire       o_confirm
);
  // Switch levels follow the door; the qualifier rides with its source.
  assign o_door_switch_a = (i_pos == 2'h1) && !i_pass_a;
  assign o_door_switch_b = (i_pos != 2'h0);
  assign o_pass_flag_a   = i_pass_a;
  assign o_confirm       = i_press;
endmodule // sdm_door_model

// ### sdm_door_monitor.v
// Behaviour
// - Drop enable when either door switch reads 0.
// - Enable after both open, both closed, acknowledged; open-first 0 at start and reintegration after passivation skip the opening.
// - Confirm not needed: acknowledge automatically after sequence.
// - Confirm needed: enable only on confirm rising edge, except the open-first 0 start.
// - Raise confirm request once door closed, ack outstanding.
// - Clear confirm request after acknowledgment accepted.
// - Passivation zeros never demand a full opening.
// - After startup hold enable low until acknowledged.
// - Open-first 0: auto acknowledge first closed reading.
// - Open-first 1 or switch 0: full sequence required.
// - Service bit 1: both-open not yet seen.
// - Service bit 2: both-closed not yet seen.
// - Service bit 5: enable missing, confirm stuck high.
// - Service bits 3,6,7 mirror status; 0,4 zero.
// - Reset: settings 1, inputs and outputs 0.
`timescale 1ns/1ps
`include "sdm_defines.vh"

module sdm_door_monitor #(
  parameter STUCK_CYCLES = (`SDM_STUCK_TIME_NS * 40'd1000 +
                            `SDM_CLK_PERIOD_PS - 40'd1) /
                           `SDM_CLK_PERIOD_PS
) (
  input  wire                  i_mclk,
  input  wire                  i_resetn,
  input  wire                  i_startup,
  input  wire                  i_door_switch_a,
  input  wire                  i_door_switch_b,
  input  wire                  i_pass_flag_a,
  input  wire                  i_pass_flag_b,
  input  wire                  i_open_first_cfg,
  input  wire                  i_confirm_needed_cfg,
  input  wire                  i_confirm,
  output reg                   o_enable,
  output reg                   o_confirm_req,
  output reg  [`SDM_SVC_W-1:0] o_service_info_byte
);

  // State codes.
  localparam [`SDM_ST_W-1:0] ST_START      = `SDM_ST_START;
  localparam [`SDM_ST_W-1:0] ST_WAIT_OPEN  = `SDM_ST_WAIT_OPEN;
  localparam [`SDM_ST_W-1:0] ST_WAIT_CLOSE = `SDM_ST_WAIT_CLOSE;
  localparam [`SDM_ST_W-1:0] ST_WAIT_ACK   = `SDM_ST_WAIT_ACK;
  localparam [`SDM_ST_W-1:0] ST_ENABLED    = `SDM_ST_ENABLED;
  localparam [`SDM_ST_W-1:0] ST_PASSIV     = `SDM_ST_PASSIV;

  // Stuck-button threshold at the counter's width.
  localparam [`SDM_STUCK_CNT_W-1:0] STUCK_LIMIT =
    STUCK_CYCLES[`SDM_STUCK_CNT_W-1:0];

  wire [`SDM_IN_W-1:0]        in_raw;
  wire [`SDM_IN_W-1:0]        in_sync;
  wire                        sw_a;
  wire                        sw_b;
  wire                        pass_a;
  wire                        pass_b;
  wire                        open_first_cfg;
  wire                        confirm_needed_cfg;
  wire                        confirm;
  wire                        source_passivated;
  wire                        both_open;
  wire                        both_closed;
  wire                        confirm_rise;
  wire                        stuck_now;

  reg  [`SDM_SETTLE_W-1:0]    settle_ff;
  reg  [`SDM_SETTLE_W-1:0]    nxt_settle;
  wire                        settled;
  reg  [`SDM_ST_W-1:0]        state_ff;
  reg  [`SDM_ST_W-1:0]        nxt_state;
  reg                         confirm_prev_ff;
  reg                         nxt_confirm_prev;
  reg  [`SDM_STUCK_CNT_W-1:0] stuck_cnt_ff;
  reg  [`SDM_STUCK_CNT_W-1:0] nxt_stuck_cnt;
  reg                         nxt_enable;
  reg                         nxt_confirm_req;
  reg  [`SDM_SVC_W-1:0]       nxt_service;

  // All pins except i_startup, clock and reset are gathered into one vector for the synchroniser.
  assign in_raw[`SDM_IN_SW_A]       = i_door_switch_a;
  assign in_raw[`SDM_IN_SW_B]       = i_door_switch_b;
  assign in_raw[`SDM_IN_PASS_A]     = i_pass_flag_a;
  assign in_raw[`SDM_IN_PASS_B]     = i_pass_flag_b;
  assign in_raw[`SDM_IN_OPEN_FIRST] = i_open_first_cfg;
  assign in_raw[`SDM_IN_CONF_NEED]  = i_confirm_needed_cfg;
  assign in_raw[`SDM_IN_CONFIRM]    = i_confirm;

  // The settings synchronise to 1 and the rest to 0, so that a freshly
  // reset monitor always takes the strictest configuration.
  sdm_sync #(
    .W       (`SDM_IN_W),
    .RST_VAL (`SDM_IN_RST)
  ) u_sync (
    .i_mclk   (i_mclk),
    .i_resetn (i_resetn),
    .i_async  (in_raw),
    .o_sync   (in_sync)
  );

  // Synchronised views of the pins.
  assign sw_a               = in_sync[`SDM_IN_SW_A];
  assign sw_b               = in_sync[`SDM_IN_SW_B];
  assign pass_a             = in_sync[`SDM_IN_PASS_A];
  assign pass_b             = in_sync[`SDM_IN_PASS_B];
  assign open_first_cfg     = in_sync[`SDM_IN_OPEN_FIRST];
  assign confirm_needed_cfg = in_sync[`SDM_IN_CONF_NEED];
  assign confirm            = in_sync[`SDM_IN_CONFIRM];

  // Door position summaries.
  assign source_passivated = pass_a | pass_b;
  assign both_open         = ~sw_a & ~sw_b;
  assign both_closed       = sw_a & sw_b;

  // A held-high button never makes an edge, so it cannot acknowledge.
  assign confirm_rise = confirm & ~confirm_prev_ff;

  // The button counts as stuck once the counter reaches its threshold.
  assign stuck_now = (stuck_cnt_ff >= STUCK_LIMIT);

  // The synchroniser flops come out of reset with the switches at 0. If
  // the start state trusted them, that reset value would look like a full
  // door opening, so the start decision waits until real pin values have
  // travelled through both flops.
  always @* begin
    nxt_settle = {settle_ff[`SDM_SETTLE_W-2:0], 1'b1};
  end

  assign settled = settle_ff[`SDM_SETTLE_W-1];

  // Sequence state machine, evaluated on every clock edge.
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_START: begin
        // Nothing is decided while a source is still passivated.
        if (!source_passivated && settled) begin
          if (!open_first_cfg && both_closed) begin
            nxt_state = ST_ENABLED;
          end else if (both_open) begin
            nxt_state = ST_WAIT_CLOSE;
          end else begin
            nxt_state = ST_WAIT_OPEN;
          end
        end
      end
      ST_WAIT_OPEN: begin
        // Zeros caused by passivation do not count as an opening.
        if (!source_passivated && both_open) begin
          nxt_state = ST_WAIT_CLOSE;
        end
      end
      ST_WAIT_CLOSE: begin
        if (source_passivated) begin
          nxt_state = ST_PASSIV;
        end else if (both_closed) begin
          if (confirm_needed_cfg) begin
            nxt_state = ST_WAIT_ACK;
          end else begin
            nxt_state = ST_ENABLED;
          end
        end
      end
      ST_WAIT_ACK: begin
        if (source_passivated) begin
          nxt_state = ST_PASSIV;
        end else if (!both_closed) begin
          // Door moved again before the operator confirmed.
          nxt_state = both_open ? ST_WAIT_CLOSE : ST_WAIT_OPEN;
        end else if (!confirm_needed_cfg) begin
          nxt_state = ST_ENABLED;
        end else if (confirm_rise) begin
          nxt_state = ST_ENABLED;
        end
      end
      ST_ENABLED: begin
        if (source_passivated) begin
          nxt_state = ST_PASSIV;
        end else if (!sw_a || !sw_b) begin
          nxt_state = both_open ? ST_WAIT_CLOSE : ST_WAIT_OPEN;
        end
      end
      ST_PASSIV: begin
        // After reintegration the door need not be opened again, only
        // closed and acknowledged.
        if (!source_passivated) begin
          if (both_closed && !confirm_needed_cfg) begin
            nxt_state = ST_ENABLED;
          end else if (both_closed) begin
            nxt_state = ST_WAIT_ACK;
          end else begin
            nxt_state = ST_WAIT_CLOSE;
          end
        end
      end
      default: begin
        // An illegal code falls back to the safe startup state.
        nxt_state = ST_START;
      end
    endcase
    // A startup request overrides everything in the same cycle.
    if (i_startup) begin
      nxt_state = ST_START;
    end
  end

  // Stuck-button counter: runs while the enable is missing and the button
  // is high, and saturates so it never wraps back below the threshold.
  always @* begin
    nxt_confirm_prev = confirm;
    nxt_stuck_cnt    = stuck_cnt_ff;
    if (i_startup || o_enable || !confirm) begin
      nxt_stuck_cnt = {`SDM_STUCK_CNT_W{1'b0}};
    end else if (!stuck_now) begin
      nxt_stuck_cnt = stuck_cnt_ff + {{(`SDM_STUCK_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Output decode from the next state, so every output is a flop that
  // changes on the same edge as the state it reports.
  always @* begin
    nxt_enable      = (nxt_state == ST_ENABLED);
    nxt_confirm_req = (nxt_state == ST_WAIT_ACK);
    nxt_service     = `SDM_SVC_RST;
    nxt_service[`SDM_SVC_NO_OPEN]  = (nxt_state == ST_WAIT_OPEN) ||
                                     (nxt_state == ST_START);
    nxt_service[`SDM_SVC_NO_CLOSE] = (nxt_state == ST_WAIT_CLOSE) ||
                                     (nxt_state == ST_PASSIV);
    nxt_service[`SDM_SVC_PASSIV]   = source_passivated;
    nxt_service[`SDM_SVC_STUCK]    = ~nxt_enable & stuck_now &
                                     ~i_startup;
    nxt_service[`SDM_SVC_ACK_REQ]  = nxt_confirm_req;
    nxt_service[`SDM_SVC_ENABLE]   = nxt_enable;
    nxt_service[`SDM_SVC_RSVD0]    = 1'b0;
    nxt_service[`SDM_SVC_RSVD4]    = 1'b0;
  end

  // State and output registers.
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      settle_ff           <= {`SDM_SETTLE_W{1'b0}};
      state_ff            <= ST_START;
      confirm_prev_ff     <= 1'b0;
      stuck_cnt_ff        <= {`SDM_STUCK_CNT_W{1'b0}};
      o_enable            <= 1'b0;
      o_confirm_req       <= 1'b0;
      o_service_info_byte <= `SDM_SVC_RST;
    end else begin
      settle_ff           <= nxt_settle;
      state_ff            <= nxt_state;
      confirm_prev_ff     <= nxt_confirm_prev;
      stuck_cnt_ff        <= nxt_stuck_cnt;
      o_enable            <= nxt_enable;
      o_confirm_req       <= nxt_confirm_req;
      o_service_info_byte <= nxt_service;
    end
  end

endmodule // sdm_door_monitor

// ### sdm_door_monitor_assertions.sv
`timescale 1ns/1ps

// Watches the monitor pins; every latency on a synchronised pin allows for two sync flops, while i_startup is checked after one cycle.
module sdm_door_monitor_assertions #(
  parameter STUCK_CYCLES = 2
) (
  input wire       i_mclk,
  input wire       i_resetn,
  input wire       i_startup,
  input wire       i_door_switch_a,
  input wire       i_door_switch_b,
  input wire       i_pass_flag_a,
  input wire       i_pass_flag_b,
  input wire       i_open_first_cfg,
  input wire       i_confirm_needed_cfg,
  input wire       i_confirm,
  input wire       o_enable,
  input wire       o_confirm_req,
  input wire [7:0] o_service_info_byte
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  // A button held through a pending request must never count as a press.
  sequence s_held;
    (i_confirm && o_confirm_req)[*6];
  endsequence
  sequence s_door_open;
    (!i_door_switch_a || !i_door_switch_b)[*5];
  endsequence

  AST_ENA_DROP: assert property (s_door_open |-> !o_enable)
    else $error("enable high while the door is open");
  AST_HELD_CONFIRM: assert property (s_held |=> o_confirm_req)
    else $error("held confirm button was accepted");
  AST_AUTO_ACK: assert property
    ((!i_confirm_needed_cfg)[*5] |-> !o_confirm_req)
    else $error("confirm request without confirm setting");
  AST_REQ_CLEARED: assert property (!(o_enable && o_confirm_req))
    else $error("request still up while enabled");
  AST_STARTUP: assert property
    (i_startup |=> !o_enable && !o_confirm_req)
    else $error("outputs not cleared by startup");
  AST_STUCK: assert property
    ((!o_enable && i_confirm && !i_startup)[*8] |-> o_service_info_byte[5])
    else $error("stuck button not reported");
  AST_SEQ_BITS: assert property
    (o_enable |-> o_service_info_byte[2:1] == 2'h0)
    else $error("sequence fault bits set while enabled");
  AST_PASS_BIT: assert property
    ((i_pass_flag_a || i_pass_flag_b)[*5] |-> o_service_info_byte[3])
    else $error("passivation bit missing");
  AST_MIRROR: assert property (o_service_info_byte[7] == o_enable &&
    o_service_info_byte[6] == o_confirm_req &&
    !o_service_info_byte[0] && !o_service_info_byte[4])
    else $error("service byte status bits wrong");
endmodule // sdm_door_monitor_assertions

bind sdm_door_monitor sdm_door_monitor_assertions #(
  .STUCK_CYCLES(STUCK_CYCLES)
) i_sdm_door_monitor_assertions (
  .i_mclk(i_mclk), .i_resetn(i_resetn), .i_startup(i_startup),
  .i_door_switch_a(i_door_switch_a), .i_door_switch_b(i_door_switch_b),
  .i_pass_flag_a(i_pass_flag_a), .i_pass_flag_b(i_pass_flag_b),
  .i_open_first_cfg(i_open_first_cfg), .i_confirm(i_confirm),
  .i_confirm_needed_cfg(i_confirm_needed_cfg), .o_enable(o_enable),
  .o_confirm_req(o_confirm_req),
  .o_service_info_byte(o_service_info_byte)
);

// ### sdm_door_monitor_tb.sv
`timescale 1ns/1ps

module sdm_door_monitor_tb;
  reg        i_mclk      = 1'b0;
  reg        i_resetn    = 1'b0;
  reg        startup     = 1'b0;
  reg  [1:0] pos         = 2'h1;
  reg        press       = 1'b0;
  reg        pass_a      = 1'b0;
  reg        open_first  = 1'b1;
  reg        conf_need   = 1'b1;
  wire       sw_a;
  wire       sw_b;
  wire       pf_a;
  wire       conf;
  wire       o_enable;
  wire       o_confirm_req;
  wire [7:0] o_service_info_byte;
  integer    miscompares = 0;
  integer    n_tests     = 0;

  always #12.5 i_mclk = ~i_mclk;

  // Short stuck time keeps the button fault visible within a few cycles.
  sdm_door_monitor #(.STUCK_CYCLES(2)) i_sdm_door_monitor (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_startup(startup),
    .i_door_switch_a(sw_a), .i_door_switch_b(sw_b),
    .i_pass_flag_a(pf_a), .i_pass_flag_b(1'b0),
    .i_open_first_cfg(open_first), .i_confirm_needed_cfg(conf_need),
    .i_confirm(conf), .o_enable(o_enable), .o_confirm_req(o_confirm_req),
    .o_service_info_byte(o_service_info_byte)
  );

  sdm_door_model i_sdm_door_model (
    .i_pos(pos), .i_press(press), .i_pass_a(pass_a),
    .o_door_switch_a(sw_a), .o_door_switch_b(sw_b),
    .o_pass_flag_a(pf_a), .o_confirm(conf)
  );

  task check(input [9:0] seen, input [9:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  // Inputs always move 2 ns after a rising edge.
  task step(input integer n);
    begin
      repeat (n) @(posedge i_mclk);
      #2;
    end
  endtask

  // Two sync flops plus the output flop; five cycles leave a margin.
  task expect_svc(input [7:0] exp);
    begin
      step(5);
      check({o_enable, o_confirm_req, o_service_info_byte}, {exp[7:6], exp});
    end
  endtask

  task print_verdict;
    begin
      if (miscompares == 0 && n_tests > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  initial begin
    step(7);
    check({o_enable, o_confirm_req, o_service_info_byte}, 10'h0);
    step(1);
    i_resetn = 1'b1;
    expect_svc(8'h02);
    pos = 2'h0;
    expect_svc(8'h04);
    // Button pressed as the door closes and held: must not acknowledge.
    press = 1'b1;
    pos = 2'h1;
    expect_svc(8'h60);
    expect_svc(8'h60);
    press = 1'b0;
    expect_svc(8'h40);
    press = 1'b1;
    expect_svc(8'h80);
    press = 1'b0;
    pos = 2'h2;
    expect_svc(8'h02);
    pos = 2'h0;
    expect_svc(8'h04);
    pos = 2'h1;
    expect_svc(8'h40);
    conf_need = 1'b0;
    expect_svc(8'h80);
    pass_a = 1'b1;
    expect_svc(8'h0c);
    pass_a = 1'b0;
    expect_svc(8'h80);
    open_first = 1'b0;
    conf_need = 1'b1;
    step(4);
    startup = 1'b1;
    step(1);
    startup = 1'b0;
    check({9'h0, o_enable}, 10'h0);
    expect_svc(8'h80);
    open_first = 1'b1;
    step(4);
    startup = 1'b1;
    step(1);
    startup = 1'b0;
    expect_svc(8'h02);
    print_verdict;
  end
endmodule // sdm_door_monitor_tb

// ### sdm_sync.v
`timescale 1ns/1ps

// Two-stage synchroniser for a group of independent level inputs.
module sdm_sync #(
  parameter                 W       = 1,
  parameter [W-1:0]         RST_VAL = {W{1'b0}}
) (
  input  wire               i_mclk,
  input  wire               i_resetn,
  input  wire [W-1:0]       i_async,
  output wire [W-1:0]       o_sync
);

  genvar g;

  // Each bit gets its own pair of flops; the first is read only by the second.
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      reg meta_ff;
      reg sync_ff;
      always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
          meta_ff <= RST_VAL[g];
          sync_ff <= RST_VAL[g];
        end else begin
          meta_ff <= i_async[g];
          sync_ff <= meta_ff;
        end
      end
      assign o_sync[g] = sync_ff;
    end
  endgenerate

endmodule // sdm_sync
